/* bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;

  // two stages; only the second stage is visible
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_r <= '0;
      q <= '0;
    end
    else
    begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule // bit_sync
`default_nettype wire

/* err_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module err_flag (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic set_ev,
  input wire logic stat_read,
  input wire logic clr_wr,
  output logic flag
);
  logic armed_r;
  logic flag_nxt;
  logic armed_nxt;

  // a clear needs a prior read of the set flag; a new event beats the clear
  assign flag_nxt = set_ev | (flag & ~(clr_wr & armed_r));
  assign armed_nxt = flag_nxt & (armed_r | (stat_read & flag));

  // only reset or an armed zero write brings the flag down
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flag <= spi_err_pkg::RST_BIT;
      armed_r <= spi_err_pkg::RST_BIT;
    end
    else
    begin
      flag <= flag_nxt;
      armed_r <= armed_nxt;
    end
  end
endmodule // err_flag
`default_nettype wire

/* far_spi.sv */
`timescale 1ns/1ps
`default_nettype none
// far side of the link: a slave answering the block as master, or a master feeding it
module far_spi (
  input wire logic pol,
  input wire logic sck_w,
  input wire logic mosi_w,
  output var logic p_sck,
  output var logic p_mosi,
  output var logic p_miso,
  output wire logic p_ssel
);
  logic act = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] got = 8'h00;
  int nbit = 0;
  initial
  begin
    p_sck = 1'b0;
    p_mosi = 1'b0;
    p_miso = 1'b0;
  end
  // one activity flag covers both polarities of the select line
  assign p_ssel = act ? pol : ~pol;
  task automatic arm(input logic [7:0] d);
    tx = d;
    nbit = 0;
    p_miso = d[7];
  endtask
  // sample on rising, released line shows the inverse so no stale bit survives
  always @(posedge sck_w)
  begin
    got = {got[6:0], mosi_w};
    nbit++;
    if (nbit == 8)
      p_miso <= #40 ~p_miso;
  end
  always @(negedge sck_w)
    if (nbit < 8)
      p_miso = tx[7-nbit];
  // master frame at 125 ns; the clock stands still outside it
  task automatic frame(input logic [7:0] d, input int drop);
    act = 1'b1;
    #200;
    for (int i = 0; i < 8; i++)
    begin
      p_mosi = d[7-i];
      if (i == drop)
        act = 1'b0;
      #62.5 p_sck = 1'b1;
      #62.5 p_sck = 1'b0;
    end
    #100 p_mosi = ~p_mosi;
    act = 1'b0;
  endtask
endmodule // far_spi
`default_nettype wire

/* spi_err_pkg.sv */
// Operation
// - transfer ending with receive buffer full sets overrun and keeps old buffer
// - master overrun copies the command pointer into the error pointer
// - data read clears receive-full and returns the buffer; overrun unaffected
// - transfer ending under overrun loads nothing and leaves receive-full as it was
// - under overrun the shift register still empties so transmit data moves on
// - overrun clears only by reset or zero write after reading it set
// - error interrupt enable requests interrupt on overrun or mode fault
// - no reception into the buffer while overrun stays set
// - multi-master mode is master, not clock-synchronous, fault detect enabled
// - active select-zero in multi-master raises mode fault and copies pointer
// - active level of select-zero comes from its polarity bit
// - slave mode faults when select-zero drops during a running transfer
// - any mode fault stops output drive and clears function enable
// - enable writes of one are ignored while mode fault is set
// - mode fault clears only by reset or zero write after reading it set
// - disabling aborts transfer, resets state, sets transmit-empty
// - disabling keeps every control bit
// - disabling keeps receive-full, overrun, mode fault and pointer status; the code clears the command pointer on disable
// - transmit interrupt requested while transmit-empty and its enable are one
// - hardware reset initialises all control, status and data
// - single-master mode never detects mode faults
// - multi-master fault stops clock, master data and select outputs
// - slave fault stops slave data output and drops the transfer
package spi_err_pkg;
  localparam int DATA_W = 8;
  localparam int PTR_W = 2;
  localparam int SEL_OUT_W = 3;
  // serial clock period made in master mode, and our own clock period
  localparam int SCK_PERIOD_NS = 125;
  localparam int CLK_PERIOD_PS = 4000;
  // half period rounds down so the clock is never slower than asked
  localparam int HALF_CYC = (SCK_PERIOD_NS * 1000) / (2 * CLK_PERIOD_PS);
  localparam int DIV_W = 8;
  localparam logic RST_TX_EMPTY = 1'h1;
  localparam logic RST_BIT = 1'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_MASTER = 3'h2,
    ST_SLAVE = 3'h4
  } xfer_state_t;

  // a select line is active when its level equals its polarity bit
  function automatic logic sel_active(input logic lvl, input logic pol);
    return lvl == pol;
  endfunction
endpackage

/* spi_error_detect_and_init_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_error_detect_and_init_tb;
  localparam int HC = 4;
  localparam int LAST = 2;
  logic clk, sys_rst, sel_pol, fe, tie, eie, ms, mfe, ow, mw, data_write;
  logic [7:0] write_data, read_data, error_command_pointer, command_pointer;
  logic [4:0] stb;
  logic function_enable, receive_full_flag, overrun_flag, mode_fault_flag;
  logic transmit_empty_flag, error_irq, transmit_irq, sck_out, sck_oe, mosi_out, mosi_oe;
  logic miso_out, miso_oe, sso_oe, sck_w, mosi_w, miso_w;
  wire logic p_sck, p_mosi, p_miso, p_ssel;
  logic [1:0] cp, ecp;
  integer seed = 75;
  int failures = 0, n_compared = 0, cyc = 0, n_eirq = 0;
  // behavioural model of the flags, buffer and pointers
  logic m_rf, m_ovr, m_mf;
  logic [7:0] m_buf;
  int m_ptr, m_ecp, m_eirq;
  assign command_pointer = {6'h00, cp};
  assign error_command_pointer = {6'h00, ecp};
  // wires resolved from the block's enables; the far side drives whenever the block does not
  assign sck_w = sck_oe ? sck_out : p_sck;
  assign mosi_w = mosi_oe ? mosi_out : p_mosi;
  assign miso_w = miso_oe ? miso_out : p_miso;
  spi_error_init #(.HALF_CYC(HC)) i_dut (.clk(clk), .sys_rst(sys_rst), .ctrl_write(stb[4]),
    .function_enable_wd(fe), .transmit_interrupt_enable_wd(tie),
    .error_interrupt_enable_wd(eie), .master_select_wd(ms), .clock_sync_select_wd(1'b0),
    .mode_fault_enable_wd(mfe), .select_zero_polarity(sel_pol), .select_out_polarity(3'h5),
    .sequence_last(2'h2), .status_read(stb[2]), .status_write(stb[3]), .overrun_wd(ow),
    .mode_fault_wd(mw), .data_write(stb[0]), .write_data(write_data), .data_read(stb[1]),
    .read_data(read_data), .function_enable(function_enable),
    .receive_full_flag(receive_full_flag), .overrun_flag(overrun_flag),
    .mode_fault_flag(mode_fault_flag), .transmit_empty_flag(transmit_empty_flag),
    .command_pointer(cp), .error_command_pointer(ecp), .error_irq(error_irq),
    .transmit_irq(transmit_irq), .serial_clock_line_in(sck_w),
    .serial_clock_line_out(sck_out), .serial_clock_line_oe(sck_oe),
    .master_data_out_line_in(mosi_w), .master_data_out_line_out(mosi_out),
    .master_data_out_line_oe(mosi_oe), .slave_data_out_line_in(miso_w),
    .slave_data_out_line_out(miso_out), .slave_data_out_line_oe(miso_oe),
    .slave_select_zero_input(p_ssel), .slave_select_out(), .slave_select_out_oe(sso_oe));
  far_spi i_far (.pol(sel_pol), .sck_w(sck_w), .mosi_w(mosi_w), .p_sck(p_sck),
    .p_mosi(p_mosi), .p_miso(p_miso), .p_ssel(p_ssel));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // error pulses and a hang limit, both counted on the clock
  always @(posedge clk)
  begin
    if (error_irq === 1'b1)
      n_eirq++;
    cyc++;
    if (cyc == 12000)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkb(input string what, input logic e, input logic g);
    chk(what, {7'h00, e}, {7'h00, g});
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    #1 stb[i] = 1'b1;
    @(posedge clk);
    #1 stb[i] = 1'b0;
  endtask
  task automatic ctrl(input logic f, input logic t, input logic m, input logic mf);
    {fe, tie, ms, mfe} = {f, t, m, mf};
    pulse(4);
  endtask
  task automatic flags(input logic te);
    chkb("receive full", m_rf, receive_full_flag);
    chkb("overrun", m_ovr, overrun_flag);
    chkb("mode fault", m_mf, mode_fault_flag);
    chkb("transmit empty", te, transmit_empty_flag);
    chk("error irqs", 8'(m_eirq), 8'(n_eirq));
  endtask
  task automatic rd();
    pulse(1);
    chk("read data", m_buf, read_data);
    m_rf = 1'b0;
  endtask
  task automatic clr(input logic armed, input logic o, input logic m);
    if (armed)
      pulse(2);
    {ow, mw} = {o, m};
    pulse(3);
    repeat (2) @(posedge clk);
  endtask
  task automatic xfer();
    logic [7:0] s;
    write_data = 8'($random(seed));
    s = 8'($random(seed));
    i_far.arm(s);
    pulse(0);
    repeat (16 * HC + 20) @(posedge clk);
    if (!m_ovr && m_rf)
    begin
      {m_ovr, m_ecp, m_eirq} = {1'b1, m_ptr, m_eirq + 1};
    end
    else if (!m_ovr)
      {m_rf, m_buf} = {1'b1, s};
    m_ptr = (m_ptr == LAST) ? 0 : m_ptr + 1;
    chk("mosi byte", write_data, i_far.got);
    flags(1'b1);
    chk("error pointer", 8'(m_ecp), error_command_pointer);
    chk("command pointer", 8'(m_ptr), command_pointer);
  endtask
  initial
  begin
    {sys_rst, stb, sel_pol, fe, tie, eie, ms, mfe, ow, mw} = {1'b1, 5'h00, 1'b1, 7'h00};
    write_data = 8'h00;
    {m_rf, m_ovr, m_mf, m_buf, m_ptr, m_ecp, m_eirq} = '0;
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    flags(1'b1);
    chkb("enable", 1'b0, function_enable);
    eie = 1'b1;
    ctrl(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (3) xfer();
    rd();
    chkb("overrun kept", 1'b1, overrun_flag);
    xfer();
    rd();
    clr(1'b0, 1'b0, 1'b1);
    flags(1'b1);
    clr(1'b1, 1'b0, 1'b1);
    m_ovr = 1'b0;
    flags(1'b1);
    $display("test overrun done");
    xfer();
    i_far.arm(8'h3c);
    pulse(0);
    repeat (10) @(posedge clk);
    ctrl(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (16 * HC + 20) @(posedge clk);
    m_ptr = 0;
    flags(1'b1);
    chkb("transmit irq", 1'b1, transmit_irq);
    chk("error pointer", 8'(m_ecp), error_command_pointer);
    chk("command pointer", 8'(m_ptr), command_pointer);
    rd();
    $display("test disable done");
    ctrl(1'b1, 1'b0, 1'b1, 1'b0);
    i_far.act = 1'b1;
    repeat (8) @(posedge clk);
    flags(1'b1);
    chkb("enable", 1'b1, function_enable);
    i_far.act = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      ctrl(1'b0, 1'b0, 1'b1, 1'b1);
      sel_pol = p[0];
      repeat (4) @(posedge clk);
      ctrl(1'b1, 1'b0, 1'b1, 1'b1);
      xfer();
      rd();
      i_far.act = 1'b1;
      repeat (8) @(posedge clk);
      {m_mf, m_ecp, m_eirq} = {1'b1, m_ptr, m_eirq + 1};
      m_ptr = 0;
      flags(1'b1);
      chk("error pointer", 8'(m_ecp), error_command_pointer);
      chk("pin enables", 8'h00, {5'h00, sck_oe, mosi_oe, sso_oe});
      ctrl(1'b1, 1'b0, 1'b1, 1'b1);
      chkb("enable refused", 1'b0, function_enable);
      i_far.act = 1'b0;
      clr(1'b1, 1'b1, 1'b0);
      m_mf = 1'b0;
      flags(1'b1);
    end
    ctrl(1'b1, 1'b0, 1'b1, 1'b1);
    chkb("enable again", 1'b1, function_enable);
    $display("test mode fault done");
    ctrl(1'b1, 1'b0, 1'b0, 1'b1);
    m_buf = 8'($random(seed));
    i_far.frame(m_buf, 9);
    repeat (10) @(posedge clk);
    m_rf = 1'b1;
    flags(1'b1);
    rd();
    i_far.frame(8'h5a, 3);
    repeat (2) @(posedge clk);
    {m_mf, m_eirq} = {1'b1, m_eirq + 1};
    flags(1'b1);
    chkb("slave pin enable", 1'b0, miso_oe);
    chkb("enable", 1'b0, function_enable);
    clr(1'b1, 1'b1, 1'b0);
    m_mf = 1'b0;
    flags(1'b1);
    $display("test slave done");
    give_verdict();
  end
endmodule // spi_error_detect_and_init_tb
`default_nettype wire

/* spi_error_init.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_error_init #(
  parameter int DATA_W = spi_err_pkg::DATA_W,
  parameter int PTR_W = spi_err_pkg::PTR_W,
  parameter int SEL_OUT_W = spi_err_pkg::SEL_OUT_W,
  parameter int HALF_CYC = spi_err_pkg::HALF_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ctrl_write,
  input wire logic function_enable_wd,
  input wire logic transmit_interrupt_enable_wd,
  input wire logic error_interrupt_enable_wd,
  input wire logic master_select_wd,
  input wire logic clock_sync_select_wd,
  input wire logic mode_fault_enable_wd,
  input wire logic select_zero_polarity,
  input wire logic [SEL_OUT_W-1:0] select_out_polarity,
  input wire logic [PTR_W-1:0] sequence_last,
  input wire logic status_read,
  input wire logic status_write,
  input wire logic overrun_wd,
  input wire logic mode_fault_wd,
  input wire logic data_write,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic data_read,
  output logic [DATA_W-1:0] read_data,
  output logic function_enable,
  output logic receive_full_flag,
  output logic overrun_flag,
  output logic mode_fault_flag,
  output logic transmit_empty_flag,
  output logic [PTR_W-1:0] command_pointer,
  output logic [PTR_W-1:0] error_command_pointer,
  output logic error_irq,
  output logic transmit_irq,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe,
  input wire logic master_data_out_line_in,
  output logic master_data_out_line_out,
  output logic master_data_out_line_oe,
  input wire logic slave_data_out_line_in,
  output logic slave_data_out_line_out,
  output logic slave_data_out_line_oe,
  input wire logic slave_select_zero_input,
  output logic [SEL_OUT_W-1:0] slave_select_out,
  output logic slave_select_out_oe
);
  localparam logic [spi_err_pkg::DIV_W-1:0] DIV_LAST = spi_err_pkg::DIV_W'(HALF_CYC - 1);
  localparam logic [7:0] BIT_LAST = 8'(DATA_W - 1);

  // control bits
  logic tie_r;
  logic eie_r;
  logic ms_r;
  logic css_r;
  logic mfe_r;
  logic fe_nxt;

  // datapath and status
  logic [DATA_W-1:0] tx_buf_r;
  logic [DATA_W-1:0] rx_buf_r;
  logic [DATA_W-1:0] shift_r;
  logic [DATA_W-1:0] shift_in;
  logic rx_full_nxt;
  logic tx_empty_nxt;
  logic shift_full_r;
  logic out_r;
  logic [7:0] bit_cnt_r;
  logic [spi_err_pkg::DIV_W-1:0] div_r;
  logic sck_r;
  spi_err_pkg::xfer_state_t st_r;
  spi_err_pkg::xfer_state_t st_nxt;

  // synchronised pins: clock, select zero, master data, slave data
  logic [3:0] pins_s;
  logic sclk_s;
  logic ss_s;
  logic mosi_s;
  logic miso_s;
  logic sclk_d_r;
  logic ss_act_d_r;

  // decode
  logic multi_master;
  logic ss_act;
  logic active;
  logic mm_fault;
  logic sl_fault;
  logic mode_fault_flag_set;
  logic ovr_set;
  logic rx_load;
  logic xfer_end;
  logic tick;
  logic m_rise;
  logic m_fall;
  logic s_rise;
  logic s_fall;
  logic rise_ev;
  logic fall_ev;
  logic din;
  logic last_bit;
  logic shift_load;
  logic ss_rise;
  logic in_master;
  logic in_slave;
  logic ptr_wrap;

  bit_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({serial_clock_line_in, slave_select_zero_input, master_data_out_line_in,
        slave_data_out_line_in}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[3];
  assign ss_s = pins_s[2];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[0];

  // mode decode and fault sources
  assign multi_master = ms_r & ~css_r & mfe_r;
  assign ss_act = spi_err_pkg::sel_active(ss_s, select_zero_polarity);
  assign mm_fault = function_enable & multi_master & ss_act;
  assign sl_fault = in_slave & ~ms_r & mfe_r & ~css_r & ~ss_act;
  assign mode_fault_flag_set = mm_fault | sl_fault;
  assign active = function_enable & ~mode_fault_flag_set;
  assign in_master = st_r == spi_err_pkg::ST_MASTER;
  assign in_slave = st_r == spi_err_pkg::ST_SLAVE;

  // bit timing: master from the divider, slave from sampled clock edges
  assign tick = in_master & (div_r == DIV_LAST);
  assign m_rise = tick & ~sck_r;
  assign m_fall = tick & sck_r;
  assign s_rise = in_slave & sclk_s & ~sclk_d_r;
  assign s_fall = in_slave & ~sclk_s & sclk_d_r;
  assign rise_ev = m_rise | s_rise;
  assign fall_ev = m_fall | s_fall;
  assign din = ms_r ? miso_s : mosi_s;
  assign shift_in = {shift_r[DATA_W-2:0], din};
  assign last_bit = bit_cnt_r == BIT_LAST;
  // a fault in the same cycle aborts the transfer, its data is lost
  assign xfer_end = rise_ev & last_bit & active;
  assign ss_rise = ss_act & ~ss_act_d_r;
  assign shift_load = active & ~shift_full_r & ~transmit_empty_flag;

  // end-of-transfer outcomes
  assign ovr_set = xfer_end & receive_full_flag & ~overrun_flag;
  assign rx_load = xfer_end & ~receive_full_flag & ~overrun_flag;
  // a new entry beats a read in the same cycle
  assign rx_full_nxt = rx_load | (receive_full_flag & ~data_read);
  assign tx_empty_nxt = ~active | shift_load |
                        (transmit_empty_flag & ~data_write);
  // writes of one are refused while a mode fault stands
  assign fe_nxt = mode_fault_flag_set ? 1'h0 :
                  ctrl_write ? (function_enable_wd & ~mode_fault_flag) :
                  function_enable;
  assign ptr_wrap = command_pointer == sequence_last;

  // transfer state; disabling returns to idle at once
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      spi_err_pkg::ST_IDLE:
        if (active & ms_r & shift_full_r)
          st_nxt = spi_err_pkg::ST_MASTER;
        else if (active & ~ms_r & ss_rise)
          st_nxt = spi_err_pkg::ST_SLAVE;
      spi_err_pkg::ST_MASTER,
      spi_err_pkg::ST_SLAVE:
        if (xfer_end)
          st_nxt = spi_err_pkg::ST_IDLE;
      default:
        st_nxt = spi_err_pkg::ST_IDLE;
    endcase
    if (!active)
      st_nxt = spi_err_pkg::ST_IDLE;
  end

  // control bits survive a disable; only reset and control writes touch them, except function enable, which a mode fault also clears
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      function_enable <= spi_err_pkg::RST_BIT;
      tie_r <= spi_err_pkg::RST_BIT;
      eie_r <= spi_err_pkg::RST_BIT;
      ms_r <= spi_err_pkg::RST_BIT;
      css_r <= spi_err_pkg::RST_BIT;
      mfe_r <= spi_err_pkg::RST_BIT;
    end
    else
    begin
      function_enable <= fe_nxt;
      if (ctrl_write)
      begin
        tie_r <= transmit_interrupt_enable_wd;
        eie_r <= error_interrupt_enable_wd;
        ms_r <= master_select_wd;
        css_r <= clock_sync_select_wd;
        mfe_r <= mode_fault_enable_wd;
      end
    end
  end

  // buffers and their flags; disabling resets only transmit side
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_buf_r <= '0;
      rx_buf_r <= '0;
      read_data <= '0;
      receive_full_flag <= spi_err_pkg::RST_BIT;
      transmit_empty_flag <= spi_err_pkg::RST_TX_EMPTY;
    end
    else
    begin
      if (data_write & transmit_empty_flag & active)
        tx_buf_r <= write_data;
      if (rx_load)
        rx_buf_r <= shift_in;
      if (data_read)
        read_data <= rx_buf_r;
      receive_full_flag <= rx_full_nxt;
      transmit_empty_flag <= tx_empty_nxt;
    end
  end

  // shift register empties at every transfer end, overrun or not
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      shift_full_r <= spi_err_pkg::RST_BIT;
    else if (!active || xfer_end)
      shift_full_r <= 1'h0;
    else if (shift_load)
      shift_full_r <= 1'h1;
  end

  // shift data: sample on rising edge, present next bit on falling edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_r <= '0;
      out_r <= spi_err_pkg::RST_BIT;
      bit_cnt_r <= '0;
    end
    else
    begin
      if (shift_load)
        shift_r <= tx_buf_r;
      else if (rise_ev)
        shift_r <= shift_in;
      if (shift_load)
        out_r <= tx_buf_r[DATA_W-1];
      else if (fall_ev)
        out_r <= shift_r[DATA_W-1];
      if (st_r == spi_err_pkg::ST_IDLE)
        bit_cnt_r <= '0;
      else if (rise_ev)
        bit_cnt_r <= bit_cnt_r + 8'h01;
    end
  end

  // master clock divider; the clock parks low outside a transfer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_r <= '0;
      sck_r <= spi_err_pkg::RST_BIT;
    end
    else if (!in_master)
    begin
      div_r <= '0;
      sck_r <= 1'h0;
    end
    else
    begin
      div_r <= tick ? '0 : div_r + 1'h1;
      if (tick)
        sck_r <= ~sck_r;
    end
  end

  // edge history of the synchronised clock and select
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_d_r <= spi_err_pkg::RST_BIT;
      ss_act_d_r <= spi_err_pkg::RST_BIT;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      ss_act_d_r <= ss_act;
    end
  end

  // state, command pointer and error pointer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= spi_err_pkg::ST_IDLE;
      command_pointer <= '0;
      error_command_pointer <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      if (!function_enable)
        command_pointer <= '0;
      else if (xfer_end & ms_r)
        command_pointer <= ptr_wrap ? '0 : command_pointer + 1'h1;
      if ((ovr_set & ms_r) | mm_fault)
        error_command_pointer <= command_pointer;
    end
  end

  // select outputs asserted only while a master transfer runs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      slave_select_out <= '0;
    else
      slave_select_out <= in_master ? select_out_polarity : ~select_out_polarity;
  end

  // error request is one pulse per detected error
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      error_irq <= spi_err_pkg::RST_BIT;
    else
      error_irq <= eie_r & (ovr_set | mode_fault_flag_set);
  end

  err_flag u_ovr (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_ev(ovr_set),
    .stat_read(status_read),
    .clr_wr(status_write & ~overrun_wd),
    .flag(overrun_flag)
  );

  err_flag u_mode_fault_flag (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_ev(mode_fault_flag_set),
    .stat_read(status_read),
    .clr_wr(status_write & ~mode_fault_wd),
    .flag(mode_fault_flag)
  );

  // master pins stay driven while disabled, dropped after a fault
  assign serial_clock_line_out = sck_r;
  assign serial_clock_line_oe = ms_r & ~mode_fault_flag;
  assign master_data_out_line_out = out_r;
  assign master_data_out_line_oe = ms_r & ~mode_fault_flag;
  assign slave_select_out_oe = ms_r & ~mode_fault_flag;
  // slave data is high impedance whenever the slave is disabled
  assign slave_data_out_line_out = out_r;
  assign slave_data_out_line_oe = ~ms_r & function_enable & in_slave;
  assign transmit_irq = tie_r & transmit_empty_flag;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_OVR_SET: assert property (ovr_set |=> overrun_flag && $stable(rx_buf_r))
    else $error("overrun not flagged or buffer overwritten");
  AST_ECP_OVR: assert property (ovr_set && ms_r && !mm_fault
    |=> error_command_pointer == $past(command_pointer))
    else $error("error pointer not captured on overrun");
  AST_RD_CLR: assert property (data_read && !rx_load
    |=> !receive_full_flag && read_data == $past(rx_buf_r) && $stable(overrun_flag))
    else $error("data read did not empty buffer");
  AST_OVR_HOLD: assert property (xfer_end && overrun_flag && !mm_fault
    |=> $stable(rx_buf_r) && $stable(error_command_pointer) && !rx_load)
    else $error("reception during overrun");
  AST_SHIFT_EMPTY: assert property (xfer_end |=> !shift_full_r)
    else $error("shift register not emptied at transfer end");
  AST_MODE_FAULT_FLAG_DIS: assert property (mode_fault_flag_set |=> mode_fault_flag && !function_enable
    && !serial_clock_line_oe && !slave_data_out_line_oe)
    else $error("mode fault did not disable");
  AST_FE_BLOCK: assert property (ctrl_write && function_enable_wd && mode_fault_flag
    |=> !function_enable)
    else $error("enable accepted under mode fault");
  AST_DIS_INIT: assert property (!function_enable
    |=> transmit_empty_flag && st_r == spi_err_pkg::ST_IDLE)
    else $error("disable did not initialise transfer state");
  AST_SINGLE: assert property (ms_r && !mfe_r |-> !mode_fault_flag_set)
    else $error("mode fault in single master");
  AST_ERR_IRQ: assert property ((ovr_set || mode_fault_flag_set) && eie_r |=> error_irq)
    else $error("error interrupt missing");
endmodule // spi_error_init
`default_nettype wire
